// *** hw/fmd_buf2.v ***
// Purpose: two-entry valid/ready buffer
// Assumes: synchronous active-low reset
// Notes: full throughput, no word lost on receiver stall
`timescale 1ns/1ps
module fmd_buf2 #(
	parameter W = 1
) (
	input wire clk_sys,
	input wire rst_b,
	input wire [W-1:0] in_data,
	input wire in_valid,
	output wire in_ready,
	output wire [W-1:0] out_data,
	output wire out_valid,
	input wire out_ready
);
	reg [W-1:0] mem_ff [0:1];
	reg rd_ff, wr_ff;
	reg [1:0] cnt_ff;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	assign in_ready = (cnt_ff != 2'h2);
	assign out_valid = (cnt_ff != 2'h0);
	assign out_data = mem_ff[rd_ff];
	always @(posedge clk_sys) begin
		if (!rst_b) begin
			rd_ff <= 1'b0;
			wr_ff <= 1'b0;
			cnt_ff <= 2'h0;
		end else begin
			if (push) begin
				mem_ff[wr_ff] <= in_data;
				wr_ff <= ~wr_ff;
			end
			if (pop)
				rd_ff <= ~rd_ff;
			if (push && !pop)
				cnt_ff <= cnt_ff + 2'h1;
			else if (pop && !push)
				cnt_ff <= cnt_ff - 2'h1;
		end
	end
endmodule // fmd_buf2

// *** hw/fmd_core.v ***
// Purpose: fiber modem datapath: clock select, async-to-sync, loopbacks, pattern test
// Assumes: clock sources and line bits come as one-cycle enables on clk_sys
// Notes: analog pll lives outside; its recovered bit enable is an input
`timescale 1ns/1ps
`include "fmd_regs.vh"
// What this block does
// [RULE1] transmit bit clock from one of three sources
// [RULE2] oscillator source uses internal oscillator tick
// [RULE3] terminal source clocks data with terminal clock
// [RULE4] recovered source loops receive clock to transmit
// [RULE5] receive data sampled on pll recovered clock
// [RULE6] external terminal clock input accepted
// [RULE7] received data buffered before terminal output
// [RULE8] installer sets jumper external for terminal source
// [RULE9] installer sets jumper internal otherwise
// [RULE10] async characters converted to synchronous line bits
// [RULE11] stop bit lengthened or shortened for mismatch
// [RULE12] character length and deviation switches set mode
// [RULE13] digital, remote and analog loopback modes
// [RULE14] loopbacks from buttons or terminal signals
// [RULE15] straps permit button and terminal activation
// [RULE16] pattern button sends continuous 511-bit pattern
// [RULE17] mismatch against expected sequence lights error
// [RULE18] checker also accepts remote-originated pattern
// [RULE19] external tester with same sequence works
// [RULE20] each loop has its documented start sources
// [RULE21] nine-stage lfsr x^9+x^5+1, self-synchronising
// [RULE22] source change idles output until stable
module fmd_core #(
	parameter SETTLE_CYC = `FMD_SETTLE_CYC
) (
	input wire clk_sys,
	input wire rst_b,
	input wire [1:0] clk_src_sel,
	input wire osc_tick,
	input wire dte_clk_tick,
	input wire rec_clk_tick,
	input wire line_rx_bit,
	input wire dte_tx_bit,
	input wire async_mode,
	input wire char_len_sel,
	input wire wide_dev_sel,
	input wire switch_permit_strap,
	input wire far_loop_strap,
	input wire line_side_loop_strap,
	input wire local_digital_loop_button,
	input wire remote_loop_button,
	input wire analog_loop_button,
	input wire dte_remote_loop_req,
	input wire dte_local_loop_req,
	input wire pattern_test_button,
	input wire rx_ready,
	output reg line_tx_bit_ff,
	output wire tx_bit_tick,
	output wire [8:0] rx_data,
	output wire rx_valid,
	output reg digital_loop_ff,
	output reg remote_loop_ff,
	output reg analog_loop_ff,
	output reg pattern_on_ff,
	output reg error_led_ff,
	output reg tx_idle_ff
);
	localparam ST_IDLE = 2'b01;
	localparam ST_RUN = 2'b10;
	reg [1:0] st_ff, nxt_st;
	reg [1:0] src_ff;
	reg [15:0] settle_ff;
	reg [15:0] err_hold_ff;
	reg [3:0] rx_cnt_ff;
	reg [8:0] rx_sh_ff;
	reg [3:0] tx_cnt_ff;
	reg rx_prev_ff;
	reg rx_busy_ff;
	reg [1:0] drop_ff;
	reg src_tick;
	wire gen_bit, chk_err;
	wire [3:0] char_bits = char_len_sel ? 4'h9 : 4'h8;
	// source pick; terminal clock used directly, no resampling
	always @* begin
		case (src_ff)
			`FMD_SRC_OSC: src_tick = osc_tick; // [RULE2]
			`FMD_SRC_DTE: src_tick = dte_clk_tick; // [RULE3] [RULE6]
			`FMD_SRC_REC: src_tick = rec_clk_tick; // [RULE4]
			default: src_tick = osc_tick;
		endcase
	end
	// ticks are enables on one clock, so switching cannot glitch
	assign tx_bit_tick = src_tick && (st_ff == ST_RUN); // [RULE1]
	always @* begin
		nxt_st = st_ff;
		case (st_ff)
			ST_IDLE: if (settle_ff == 16'h0000 && clk_src_sel == src_ff) nxt_st = ST_RUN; // [RULE22]
			ST_RUN: if (clk_src_sel != src_ff) nxt_st = ST_IDLE; // [RULE22]
			default: nxt_st = ST_IDLE;
		endcase
	end
	always @(posedge clk_sys) begin
		if (!rst_b) begin
			st_ff <= ST_IDLE;
			src_ff <= `FMD_SRC_OSC;
			settle_ff <= 16'h0000;
			tx_idle_ff <= 1'b1;
		end else begin
			st_ff <= nxt_st;
			tx_idle_ff <= (nxt_st == ST_IDLE);
			// a change while still settling restarts the wait
			if (clk_src_sel != src_ff) begin
				src_ff <= clk_src_sel;
				settle_ff <= SETTLE_CYC[15:0]; // [RULE22]
			end else if (settle_ff != 16'h0000)
				settle_ff <= settle_ff - 16'h0001;
		end
	end
	// loop activation gated by straps
	wire sw_ok = switch_permit_strap;
	wire dig_req = sw_ok && local_digital_loop_button; // [RULE20] [RULE15]
	wire rem_req = far_loop_strap && ((sw_ok && remote_loop_button) || dte_remote_loop_req); // [RULE14] [RULE15]
	wire ana_req = line_side_loop_strap && ((sw_ok && analog_loop_button) || dte_local_loop_req); // [RULE14] [RULE15]
	always @(posedge clk_sys) begin
		if (!rst_b) begin
			digital_loop_ff <= 1'b0;
			remote_loop_ff <= 1'b0;
			analog_loop_ff <= 1'b0;
			pattern_on_ff <= 1'b0;
		end else begin
			digital_loop_ff <= dig_req; // [RULE13]
			remote_loop_ff <= rem_req; // [RULE13]
			analog_loop_ff <= ana_req; // [RULE13]
			pattern_on_ff <= pattern_test_button; // [RULE16]
		end
	end
	// async-to-sync: stop bit stretched while terminal idles, start taken on a fall
	wire start_fall = rx_prev_ff && !dte_tx_bit;
	// wide deviation: one char in four may start without a full stop bit
	wire start_cut = wide_dev_sel && (drop_ff == 2'h3) && !dte_tx_bit; // [RULE11] [RULE12]
	wire async_start = async_mode && (tx_cnt_ff == 4'h0) && (start_fall || start_cut);
	always @(posedge clk_sys) begin
		if (!rst_b) begin
			tx_cnt_ff <= 4'h0;
			rx_prev_ff <= 1'b1;
			drop_ff <= 2'h0;
		end else if (tx_bit_tick) begin
			rx_prev_ff <= dte_tx_bit;
			if (tx_cnt_ff != 4'h0)
				tx_cnt_ff <= tx_cnt_ff - 4'h1;
			else if (async_start) begin
				tx_cnt_ff <= char_bits; // [RULE10] [RULE12]
				drop_ff <= (wide_dev_sel && !start_cut) ? drop_ff + 2'h1 : 2'h0; // [RULE11] [RULE12]
			end
		end
	end
	// data slots pass through; between chars the line holds the stop level
	wire async_bit = (tx_cnt_ff != 4'h0 || async_start) ? dte_tx_bit : 1'b1; // [RULE10] [RULE11]
	always @(posedge clk_sys) begin
		if (!rst_b)
			line_tx_bit_ff <= 1'b1;
		else if (tx_idle_ff)
			line_tx_bit_ff <= 1'b1; // [RULE22]
		else if (tx_bit_tick) begin
			if (pattern_on_ff)
				line_tx_bit_ff <= gen_bit; // [RULE16]
			else if (digital_loop_ff || remote_loop_ff)
				line_tx_bit_ff <= line_rx_bit; // [RULE13]
			else if (async_mode)
				line_tx_bit_ff <= async_bit; // [RULE10]
			else
				line_tx_bit_ff <= dte_tx_bit; // [RULE3]
		end
	end
	// receive side: analog loop hears its own transmit
	wire rx_bit = analog_loop_ff ? line_tx_bit_ff : line_rx_bit; // [RULE13]
	wire rx_tick = analog_loop_ff ? tx_bit_tick : rec_clk_tick; // [RULE5]
	always @(posedge clk_sys) begin
		if (!rst_b) begin
			rx_cnt_ff <= 4'h0;
			rx_sh_ff <= 9'h000;
			rx_busy_ff <= 1'b0;
		end else if (rx_tick) begin
			rx_sh_ff <= {rx_sh_ff[7:0], rx_bit}; // [RULE5]
			rx_cnt_ff <= (rx_cnt_ff == 4'h8) ? 4'h0 : rx_cnt_ff + 4'h1;
			rx_busy_ff <= (rx_cnt_ff == 4'h8);
		end else
			rx_busy_ff <= 1'b0;
	end
	// nine-bit words; a word arriving while full is the only loss path
	fmd_buf2 #(.W(9)) u_rxbuf (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.in_data(rx_sh_ff),
		.in_valid(rx_busy_ff),
		.in_ready(),
		.out_data(rx_data),
		.out_valid(rx_valid),
		.out_ready(rx_ready)
	); // [RULE7]
	fmd_prbs u_prbs (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.gen_en(tx_bit_tick && pattern_on_ff),
		.gen_bit(gen_bit),
		.chk_en(rx_tick),
		.chk_bit(rx_bit),
		.chk_sync(),
		.chk_err(chk_err)
	); // [RULE18] [RULE19]
	// error led stretched so a single bit error is visible
	always @(posedge clk_sys) begin
		if (!rst_b) begin
			err_hold_ff <= 16'h0000;
			error_led_ff <= 1'b0;
		end else begin
			if (chk_err)
				err_hold_ff <= `FMD_ERR_HOLD; // [RULE17]
			else if (err_hold_ff != 16'h0000)
				err_hold_ff <= err_hold_ff - 16'h0001;
			error_led_ff <= chk_err || (err_hold_ff != 16'h0000); // [RULE17]
		end
	end
endmodule // fmd_core

// *** hw/fmd_prbs.v ***
// Purpose: 511-bit pattern generator and self-synchronising checker
// Assumes: bit enables are one-cycle pulses
// Notes: nine-stage lfsr, x^9+x^5+1
`timescale 1ns/1ps
`include "fmd_regs.vh"
module fmd_prbs (
	input wire clk_sys,
	input wire rst_b,
	input wire gen_en,
	output wire gen_bit,
	input wire chk_en,
	input wire chk_bit,
	output wire chk_sync,
	output wire chk_err
);
	reg [8:0] gen_ff, chk_ff;
	reg [3:0] good_ff;
	function fb;
		input [8:0] s;
		begin
			fb = s[`FMD_PRBS_TAP_HI] ^ s[`FMD_PRBS_TAP_LO];
		end
	endfunction
	wire exp_bit = fb(chk_ff);
	assign gen_bit = gen_ff[8];
	assign chk_sync = (good_ff == `FMD_SYNC_GOOD);
	assign chk_err = chk_en && chk_sync && (exp_bit != chk_bit);
	always @(posedge clk_sys) begin
		if (!rst_b) begin
			gen_ff <= `FMD_PRBS_SEED;
			chk_ff <= 9'h000;
			good_ff <= 4'h0;
		end else begin
			if (gen_en)
				gen_ff <= {gen_ff[7:0], fb(gen_ff)}; // [RULE21]
			if (chk_en) begin
				// received bits feed the register: self-synchronising
				chk_ff <= {chk_ff[7:0], chk_bit}; // [RULE21]
				if (exp_bit != chk_bit)
					good_ff <= chk_sync ? good_ff : 4'h0;
				else if (!chk_sync)
					good_ff <= good_ff + 4'h1;
			end
		end
	end
endmodule // fmd_prbs

// *** hw/fmd_regs.vh ***
// Purpose: constants for the fiber modem datapath core
// Assumes: single 125 MHz system clock, synchronous active-low reset
// Notes: clock sources arrive as one-cycle enable pulses
`ifndef FMD_REGS_VH
`define FMD_REGS_VH
`define FMD_SRC_OSC 2'h0
`define FMD_SRC_DTE 2'h1
`define FMD_SRC_REC 2'h2
`define FMD_PRBS_SEED 9'h1ff
`define FMD_PRBS_TAP_HI 8
`define FMD_PRBS_TAP_LO 4
`define FMD_SETTLE_NS 1000
`define FMD_CLK_NS 8
`define FMD_SETTLE_CYC ((`FMD_SETTLE_NS + `FMD_CLK_NS - 1) / `FMD_CLK_NS)
`define FMD_ERR_HOLD 16'hffff
`define FMD_SYNC_GOOD 4'h9
`endif

// *** sim/fmd_core_bench.sv ***
// Purpose: scenario bench for fmd_core
// Assumes: settle cut to 4 cycles
// Notes: far end echoes the line back
`timescale 1ns/1ps
module fmd_core_bench;
reg clk_sys = 1'h0;
reg rst_b = 1'h0;
reg [1:0] clk_src_sel = 2'h0;
reg [2:0] osc_cnt = 3'h0;
reg osc_tick = 1'h0, dte_tx_bit = 1'h1, async_mode = 1'h0, char_len_sel = 1'h0, wide_dev_sel = 1'h0;
reg switch_permit_strap = 1'h0, far_loop_strap = 1'h0, line_side_loop_strap = 1'h0, flip_err = 1'h0;
reg x21b_timing_jumper = 1'h0;
reg local_digital_loop_button = 1'h0, remote_loop_button = 1'h0, analog_loop_button = 1'h0;
reg dte_remote_loop_req = 1'h0, dte_local_loop_req = 1'h0, pattern_test_button = 1'h0, rx_ready = 1'h1;
wire dte_clk_tick, rec_clk_tick, line_rx_bit, line_tx_bit_ff, tx_bit_tick, rx_valid, digital_loop_ff;
wire remote_loop_ff, analog_loop_ff, pattern_on_ff, error_led_ff, tx_idle_ff;
wire [8:0] rx_data;
integer fail_count = 0;
integer n_compared = 0;
integer i;
integer e;
initial forever #4 clk_sys = ~clk_sys;
always @(negedge clk_sys) begin
	osc_cnt <= osc_cnt + 3'h1;
	osc_tick <= osc_cnt == 3'h0;
end
fmd_core #(.SETTLE_CYC(4)) dut_u (.clk_sys, .rst_b, .clk_src_sel, .osc_tick, .dte_clk_tick, .rec_clk_tick,
	.line_rx_bit, .dte_tx_bit, .async_mode, .char_len_sel, .wide_dev_sel, .switch_permit_strap, .far_loop_strap,
	.line_side_loop_strap, .local_digital_loop_button, .remote_loop_button, .analog_loop_button,
	.dte_remote_loop_req, .dte_local_loop_req, .pattern_test_button, .rx_ready, .line_tx_bit_ff, .tx_bit_tick,
	.rx_data, .rx_valid, .digital_loop_ff, .remote_loop_ff, .analog_loop_ff, .pattern_on_ff, .error_led_ff,
	.tx_idle_ff);
fmd_far_end far_u (.clk_sys, .line_tx_bit_ff, .x21b_timing_jumper, .flip_err, .dte_clk_tick, .rec_clk_tick,
	.line_rx_bit);
task chk(input [63:0] name, input [8:0] seen, input [8:0] exp);
	begin
		n_compared = n_compared + 1;
		if (seen !== exp) begin
			fail_count = fail_count + 1;
			$display("wrong value %0s expected %h seen %h", name, exp, seen);
		end
	end
endtask
task tally_and_finish;
	begin
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	end
endtask
task cyc(input integer n);
	repeat (n) @(negedge clk_sys);
endtask
task do_reset;
	begin
		rst_b = 1'h0;
		cyc(8);
		chk("idle", tx_idle_ff, 1'h1);
		chk("line", line_tx_bit_ff, 1'h1);
		rst_b = 1'h1;
	end
endtask
task t_src;
	for (i = 1; i < 4; i = i + 1) begin
		clk_src_sel = i % 3;
		x21b_timing_jumper = (i == 1);
		cyc(1);
		chk("idle", tx_idle_ff, 1'h1);
		cyc(20);
		e = 0;
		repeat (40) begin
			@(negedge clk_sys);
			#1;
			if (tx_bit_tick !== (i == 3 ? osc_tick : i == 1 ? dte_clk_tick : rec_clk_tick))
				e = e + 1;
		end
		chk("tick", e, 9'h0);
		$display("source %0d done", i % 3);
	end
endtask
task t_pat;
	begin
		clk_src_sel = 2'h2;
		cyc(20);
		pattern_test_button = 1'h1;
		cyc(300);
		chk("pat", pattern_on_ff, 1'h1);
		chk("led", error_led_ff, 1'h0);
		flip_err = 1'h1;
		cyc(4);
		flip_err = 1'h0;
		cyc(20);
		chk("led", error_led_ff, 1'h1);
		pattern_test_button = 1'h0;
		$display("pattern done");
	end
endtask
task t_loop;
	begin
		for (i = 0; i < 2; i = i + 1) begin
			{switch_permit_strap, far_loop_strap, line_side_loop_strap} = {3{i[0]}};
			remote_loop_button = 1'h1;
			cyc(3);
			chk("rem", remote_loop_ff, i[0]);
			remote_loop_button = 1'h0;
			analog_loop_button = 1'h1;
			cyc(3);
			chk("ana", analog_loop_ff, i[0]);
			analog_loop_button = 1'h0;
			cyc(3);
		end
		local_digital_loop_button = 1'h1;
		cyc(3);
		chk("dig", digital_loop_ff, 1'h1);
		local_digital_loop_button = 1'h0;
		switch_permit_strap = 1'h0;
		dte_remote_loop_req = 1'h1;
		cyc(3);
		chk("rem", remote_loop_ff, 1'h1);
		dte_remote_loop_req = 1'h0;
		dte_local_loop_req = 1'h1;
		cyc(3);
		chk("ana", analog_loop_ff, 1'h1);
		dte_local_loop_req = 1'h0;
		remote_loop_button = 1'h1;
		cyc(3);
		chk("rem", remote_loop_ff, 1'h0);
		remote_loop_button = 1'h0;
		$display("loops done");
	end
endtask
task t_buf;
	begin
		rx_ready = 1'h0;
		cyc(200);
		chk("rxv", rx_valid, 1'h1);
		chk("rxd", rx_data, 9'h1ff);
		rx_ready = 1'h1;
		i = 0;
		while (rx_valid === 1'h1 && i < 40) begin
			cyc(1);
			i = i + 1;
		end
		chk("drain", rx_valid, 1'h0);
		$display("buffer done");
	end
endtask
task t_async;
	begin
		clk_src_sel = 2'h0;
		async_mode = 1'h1;
		for (i = 0; i < 2; i = i + 1) begin
			char_len_sel = i[0];
			cyc(20);
			dte_tx_bit = 1'h0;
			e = 0;
			repeat (150) begin
				@(negedge clk_sys);
				if (line_tx_bit_ff === 1'h0)
					e = e + 1;
			end
			// start plus data slots, eight system cycles per oscillator tick
			chk("slots", e, i[0] ? 9'h050 : 9'h048);
			chk("stop", line_tx_bit_ff, 1'h1);
			dte_tx_bit = 1'h1;
		end
		cyc(20);
		async_mode = 1'h0;
		$display("async done");
	end
endtask
initial begin
	do_reset;
	t_src;
	t_pat;
	do_reset;
	t_loop;
	t_buf;
	t_async;
	tally_and_finish;
end
initial begin
	#100000;
	fail_count = fail_count + 1;
	tally_and_finish;
end
endmodule // fmd_core_bench

// *** sim/fmd_core_monitor.sv ***
// Purpose: port checker for fmd_core
// Assumes: sync active-low reset
// Notes: led stretch too long to check here
`timescale 1ns/1ps
module fmd_core_monitor (
	input wire clk_sys,
	input wire rst_b,
	input wire [1:0] clk_src_sel,
	input wire osc_tick,
	input wire dte_clk_tick,
	input wire rec_clk_tick,
	input wire far_loop_strap,
	input wire line_side_loop_strap,
	input wire pattern_test_button,
	input wire rx_ready,
	input wire line_tx_bit_ff,
	input wire tx_bit_tick,
	input wire [8:0] rx_data,
	input wire rx_valid,
	input wire remote_loop_ff,
	input wire analog_loop_ff,
	input wire pattern_on_ff,
	input wire tx_idle_ff
);
default clocking @(posedge clk_sys); endclocking
default disable iff (!rst_b);
sequence s_run;
	!tx_idle_ff && $stable(clk_src_sel);
endsequence
sequence s_quiet;
	!tx_idle_ff && !$past(tx_idle_ff) && !$past(tx_bit_tick);
endsequence
property p_src;
	s_run |-> tx_bit_tick == (clk_src_sel == 2'h0 ? osc_tick : clk_src_sel == 2'h1 ? dte_clk_tick : rec_clk_tick);
endproperty
property p_chg;
	!$stable(clk_src_sel) |=> tx_idle_ff;
endproperty
property p_idle;
	tx_idle_ff ##1 tx_idle_ff |-> line_tx_bit_ff;
endproperty
property p_hold;
	s_quiet |-> $stable(line_tx_bit_ff);
endproperty
property p_rem;
	!far_loop_strap |=> !remote_loop_ff;
endproperty
property p_ana;
	!line_side_loop_strap |=> !analog_loop_ff;
endproperty
property p_pat;
	pattern_test_button |=> pattern_on_ff;
endproperty
property p_buf;
	rx_valid && !rx_ready |=> rx_valid && $stable(rx_data);
endproperty
a_src: assert property (p_src) else $error("tick not from source");
a_chg: assert property (p_chg) else $error("no idle on change");
a_idle: assert property (p_idle) else $error("line not high in idle");
a_hold: assert property (p_hold) else $error("line moved off tick");
a_rem: assert property (p_rem) else $error("remote loop unstrapped");
a_ana: assert property (p_ana) else $error("analog loop unstrapped");
a_pat: assert property (p_pat) else $error("pattern not on");
a_buf: assert property (p_buf) else $error("word lost in stall");
endmodule // fmd_core_monitor
bind fmd_core fmd_core_monitor mon_u (.clk_sys, .rst_b, .clk_src_sel, .osc_tick, .dte_clk_tick, .rec_clk_tick,
	.far_loop_strap, .line_side_loop_strap, .pattern_test_button, .rx_ready, .line_tx_bit_ff, .tx_bit_tick,
	.rx_data, .rx_valid, .remote_loop_ff, .analog_loop_ff, .pattern_on_ff, .tx_idle_ff);

// *** sim/fmd_far_end.sv ***
// Purpose: far modem and terminal clocks
// Assumes: far unit loops our line back
// Notes: flip_err corrupts the echo only on command
`timescale 1ns/1ps
module fmd_far_end (
	input wire clk_sys,
	input wire line_tx_bit_ff,
	input wire x21b_timing_jumper,
	input wire flip_err,
	output reg dte_clk_tick,
	output reg rec_clk_tick,
	output reg line_rx_bit
);
reg [4:0] cnt_ff = 5'h0;
initial {dte_clk_tick, rec_clk_tick, line_rx_bit} = 3'h1;
always @(negedge clk_sys) begin
	cnt_ff <= cnt_ff + 5'h1;
	rec_clk_tick <= cnt_ff[1:0] == 2'h0;
	// terminal clock only reaches the modem with the jumper at external
	dte_clk_tick <= x21b_timing_jumper && (cnt_ff % 5'h5 == 5'h0);
	line_rx_bit <= line_tx_bit_ff ^ flip_err;
end
endmodule // fmd_far_end
